// ==== design/tpmc_map.vh ====
// tpmc_map.vh: offsets, field positions and reset values of the channel pair control
// assumes: included by bare name from the design files
`ifndef TPMC_MAP_VH
`define TPMC_MAP_VH
`define TPMC_CTL0_ADDR 8'h18
`define TPMC_STAT_ADDR 8'h1C
`define TPMC_CTL0_RESET 32'h00000000
`define TPMC_CTL0_WMASK 32'hF000FBFB
`define TPMC_CH1_MS_HI 31
`define TPMC_CH0_MS_HI 30
`define TPMC_CH1_ADD_SEN 29
`define TPMC_CH0_ADD_SEN 28
`define TPMC_CH1_CLR_EN 15
`define TPMC_CH1_CTL_HI 14
`define TPMC_CH1_CTL_LO 12
`define TPMC_CH1_SEN 11
`define TPMC_CH1_MS_LO_HI 9
`define TPMC_CH1_MS_LO_LO 8
`define TPMC_CH0_CLR_EN 7
`define TPMC_CH0_CTL_HI 6
`define TPMC_CH0_CTL_LO 4
`define TPMC_CH0_SEN 3
`define TPMC_CH0_MS_LO_HI 1
`define TPMC_CH0_MS_LO_LO 0
`define TPMC_PROTECTION_LEVEL_LOCKED 2'h3
`define TPMC_MS_OUTPUT 3'h0
`define TPMC_MMSEL_SINGLE 2'h0
`define TPMC_OC_HOLD 3'h0
`define TPMC_OC_SET 3'h1
`define TPMC_OC_CLEAR 3'h2
`define TPMC_OC_TOGGLE 3'h3
`define TPMC_OC_LOW 3'h4
`define TPMC_OC_HIGH 3'h5
`define TPMC_OC_PWM0 3'h6
`define TPMC_OC_PWM1 3'h7
`define TPMC_RESP_OKAY 2'h0
`define TPMC_RESP_SLVERR 2'h2
`endif

// ==== design/tpmc_ref_gen.v ====
// tpmc_ref_gen.v: compare reference generator for one channel
// assumes: match, counter relation and clear inputs already in the aclk domain
`timescale 1ns/1ns
`default_nettype none
`include "tpmc_map.vh"
module tpmc_ref_gen
(
  input wire aclk,
  input wire aresetn,
  input wire enable,
  input wire [2:0] mode,
  input wire match,
  input wire below,
  input wire count_down,
  input wire clear_en,
  input wire clear_in,
  output reg ref_r
);
  reg ref_nxt;
  reg pwm_active;

  // reference behaviour per compare control code
  always @*
  begin
    pwm_active = count_down ? !(!below && !match) : below;
    ref_nxt = ref_r;
    case (mode)
      `TPMC_OC_HOLD: ref_nxt = ref_r;
      `TPMC_OC_SET: if (match) ref_nxt = 1'b1;
      `TPMC_OC_CLEAR: if (match) ref_nxt = 1'b0;
      `TPMC_OC_TOGGLE: if (match) ref_nxt = !ref_r;
      `TPMC_OC_LOW: ref_nxt = 1'b0;
      `TPMC_OC_HIGH: ref_nxt = 1'b1;
      `TPMC_OC_PWM0: ref_nxt = pwm_active;
      `TPMC_OC_PWM1: ref_nxt = !pwm_active;
      default: ref_nxt = ref_r;
    endcase
    if (!enable)
      ref_nxt = 1'b0;
    if (clear_en && clear_in)
      ref_nxt = 1'b0; // external clear wins
  end

  // reference register
  always @(posedge aclk)
  begin
    if (!aresetn)
      ref_r <= 1'b0;
    else
      ref_r <= ref_nxt;
  end
endmodule
`default_nettype wire

// ==== design/tpmc_top.v ====
// tpmc_top.v: channel pair control register with write locks and compare references
// assumes: AXI4-Lite master on aclk; pin inputs asynchronous, other inputs on aclk
// Contract
// - Each mode selector is three bits: bit 31 and 9:8 for channel 1, bit 30 top for channel 0.
// - Bit 28 makes channel 0's extra compare value load only at update events.
// - Bit 29 does the same for channel 1's extra compare value.
// - Bit 28 is write-locked while protection is 11 and channel 0 mode is output.
// - Channel 1 mode changes only while the channel and, in multi mode, its partner are off.
// - Channel 1 mode 000 output, 001 own input, 010 internal trigger, 100 multi input.
// - With bit 7 set, a high filtered external trigger clears channel 0's reference.
// - Channel 1 has clear enable 15, output control 14:12 and buffering 11 like channel 0.
// - Channel 0 output control 6:4 selects hold, set, clear, toggle, low, high, pwm0, pwm1.
// - Channel 0 mode low bits are 1:0; 000 is output, the rest pick an input.
// - Bit 3 makes channel 0's main compare value load only at update events.
`timescale 1ns/1ns
`default_nettype none
`include "tpmc_map.vh"
module tpmc_top
(
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] protection_level,
  input wire [1:0] multi_ch1_mode_select,
  input wire ch1_output_enable,
  input wire multi_ch1_output_enable,
  input wire update_event,
  input wire [15:0] ch0_add_compare_wr,
  input wire [15:0] ch1_add_compare_wr,
  input wire [15:0] ch0_compare_wr,
  input wire [15:0] ch1_compare_wr,
  input wire filtered_external_trigger,
  input wire [1:0] ch_match,
  input wire [1:0] ch_below,
  input wire count_down,
  output reg [31:0] channel_pair_control_0,
  output reg [15:0] ch0_additional_compare_value,
  output reg [15:0] ch1_additional_compare_value,
  output reg [15:0] ch0_compare_value,
  output reg [15:0] ch1_compare_value,
  output reg ch0_compare_reference,
  output reg ch1_compare_reference
);
  reg [31:0] ctl_nxt;
  reg [31:0] wdata_r;
  reg [7:0] awaddr_r;
  reg aw_held_r;
  reg w_held_r;
  reg etr_meta_r;
  reg etr_sync_r;
  reg [3:0] s_axi_wstrb_r;
  reg [2:0] ch0_ms;
  reg [2:0] ch1_ms;
  wire do_write;
  wire ch0_out_lock;
  wire ch1_ms_lock;
  wire [1:0] ref_w;

  // both mode selectors gathered from their split bits
  always @*
  begin
    ch0_ms = {channel_pair_control_0[`TPMC_CH0_MS_HI],
      channel_pair_control_0[`TPMC_CH0_MS_LO_HI:`TPMC_CH0_MS_LO_LO]};
    ch1_ms = {channel_pair_control_0[`TPMC_CH1_MS_HI],
      channel_pair_control_0[`TPMC_CH1_MS_LO_HI:`TPMC_CH1_MS_LO_LO]};
  end

  // lock conditions
  assign ch0_out_lock = (protection_level == `TPMC_PROTECTION_LEVEL_LOCKED) &&
    (ch0_ms[2:0] == `TPMC_MS_OUTPUT);
  assign ch1_ms_lock = (multi_ch1_mode_select == `TPMC_MMSEL_SINGLE) ? ch1_output_enable :
    (ch1_output_enable || multi_ch1_output_enable);

  // write fires once address and data both held
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  // merge write into register, locked fields kept
  always @*
  begin
    ctl_nxt = (channel_pair_control_0 & ~`TPMC_CTL0_WMASK) |
      (wdata_r & `TPMC_CTL0_WMASK);
    if (ch0_out_lock)
      ctl_nxt[`TPMC_CH0_ADD_SEN] = channel_pair_control_0[`TPMC_CH0_ADD_SEN];
    if (ch1_ms_lock)
    begin
      ctl_nxt[`TPMC_CH1_MS_HI] = channel_pair_control_0[`TPMC_CH1_MS_HI];
      ctl_nxt[`TPMC_CH1_MS_LO_HI:`TPMC_CH1_MS_LO_LO] =
        channel_pair_control_0[`TPMC_CH1_MS_LO_HI:`TPMC_CH1_MS_LO_LO];
    end
  end

  // axi4-lite write channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TPMC_RESP_OKAY;
      channel_pair_control_0 <= `TPMC_CTL0_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_r <= s_axi_wdata;
        w_held_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `TPMC_RESP_OKAY;
        if ({awaddr_r[7:2], 2'b00} == `TPMC_CTL0_ADDR)
        begin
          if (s_axi_wstrb_r == 4'hF)
            channel_pair_control_0 <= ctl_nxt;
          else
            s_axi_bresp <= `TPMC_RESP_SLVERR;
        end
        else if ({awaddr_r[7:2], 2'b00} != `TPMC_STAT_ADDR)
          s_axi_bresp <= `TPMC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // byte strobes kept with the data
  always @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_wstrb_r <= 4'h0;
    else if (s_axi_wvalid && s_axi_wready)
      s_axi_wstrb_r <= s_axi_wstrb;
  end

  // axi4-lite read channel; status word shows locks and references
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TPMC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `TPMC_RESP_OKAY;
      if ({s_axi_araddr[7:2], 2'b00} == `TPMC_CTL0_ADDR)
        s_axi_rdata <= channel_pair_control_0;
      else if ({s_axi_araddr[7:2], 2'b00} == `TPMC_STAT_ADDR)
        s_axi_rdata <= {28'h0000000, ch1_ms_lock, ch0_out_lock,
          ch1_compare_reference, ch0_compare_reference};
      else
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `TPMC_RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // compare values: buffered loads wait for the update event
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ch0_additional_compare_value <= 16'h0000;
      ch1_additional_compare_value <= 16'h0000;
      ch0_compare_value <= 16'h0000;
      ch1_compare_value <= 16'h0000;
    end
    else
    begin
      if (!channel_pair_control_0[`TPMC_CH0_ADD_SEN] || update_event)
        ch0_additional_compare_value <= ch0_add_compare_wr;
      if (!channel_pair_control_0[`TPMC_CH1_ADD_SEN] || update_event)
        ch1_additional_compare_value <= ch1_add_compare_wr;
      if (!channel_pair_control_0[`TPMC_CH0_SEN] || update_event)
        ch0_compare_value <= ch0_compare_wr;
      if (!channel_pair_control_0[`TPMC_CH1_SEN] || update_event)
        ch1_compare_value <= ch1_compare_wr;
    end
  end

  // external trigger pin synchroniser
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      etr_meta_r <= 1'b0;
      etr_sync_r <= 1'b0;
    end
    else
    begin
      etr_meta_r <= filtered_external_trigger;
      etr_sync_r <= etr_meta_r;
    end
  end

  // reference generators, only in output mode
  tpmc_ref_gen u_ref0
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(ch0_ms[2:0] == `TPMC_MS_OUTPUT),
    .mode(channel_pair_control_0[`TPMC_CH0_CTL_HI:`TPMC_CH0_CTL_LO]),
    .match(ch_match[0]),
    .below(ch_below[0]),
    .count_down(count_down),
    .clear_en(channel_pair_control_0[`TPMC_CH0_CLR_EN]),
    .clear_in(etr_sync_r),
    .ref_r(ref_w[0])
  );

  tpmc_ref_gen u_ref1
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(ch1_ms[2:0] == `TPMC_MS_OUTPUT),
    .mode(channel_pair_control_0[`TPMC_CH1_CTL_HI:`TPMC_CH1_CTL_LO]),
    .match(ch_match[1]),
    .below(ch_below[1]),
    .count_down(count_down),
    .clear_en(channel_pair_control_0[`TPMC_CH1_CLR_EN]),
    .clear_in(etr_sync_r),
    .ref_r(ref_w[1])
  );

  // registered reference outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ch0_compare_reference <= 1'b0;
      ch1_compare_reference <= 1'b0;
    end
    else
    begin
      ch0_compare_reference <= ref_w[0];
      ch1_compare_reference <= ref_w[1];
    end
  end
endmodule
`default_nettype wire

// ==== tb/tpmc_checker.sv ====
// tpmc_checker.sv: concurrent checks on the channel pair control ports
// assumes: bound to tpmc_top, one clock, aresetn synchronous active low
`timescale 1ns/1ns
`default_nettype none
module tpmc_checker
(
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire [1:0] protection_level,
  input wire [1:0] multi_ch1_mode_select,
  input wire ch1_output_enable,
  input wire multi_ch1_output_enable,
  input wire update_event,
  input wire [15:0] ch0_add_compare_wr,
  input wire filtered_external_trigger,
  input wire [31:0] channel_pair_control_0,
  input wire [15:0] ch0_additional_compare_value,
  input wire [15:0] ch1_additional_compare_value,
  input wire ch0_compare_reference,
  input wire ch1_compare_reference
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // decoded register fields
  wire [31:0] cpc = channel_pair_control_0;
  wire ch0_oc = {cpc[30], cpc[1:0]} == 3'h0;
  wire ch1_oc = {cpc[31], cpc[9:8]} == 3'h0;
  wire ch1_act = ch1_output_enable || (multi_ch1_mode_select[0] && multi_ch1_output_enable);
  // multi-cycle conditions behind the reference checks
  sequence hi0_s;
    (cpc[6:4] == 3'h5 && !cpc[7] && ch0_oc)[*3];
  endsequence
  sequence hi1_s;
    (cpc[14:12] == 3'h5 && !cpc[15] && ch1_oc)[*3];
  endsequence
  sequence clr_s;
    (cpc[7] && filtered_external_trigger)[*5];
  endsequence
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  reserved_zero_a: assert property ((cpc & 32'h0FFF0404) == 32'h0)
    else $error("reserved bit set");
  ch0_lock_a: assert property (protection_level == 2'h3 && ch0_oc |=> $stable(cpc[28]))
    else $error("locked buffer bit changed");
  ch1_lock_a: assert property (ch1_act |=> $stable({cpc[31], cpc[9:8]}))
    else $error("active channel mode changed");
  add0_direct_a: assert property (!cpc[28] |=> ch0_additional_compare_value == $past(ch0_add_compare_wr))
    else $error("direct copy not following");
  add1_held_a: assert property (cpc[29] && !update_event |=> $stable(ch1_additional_compare_value))
    else $error("buffered copy moved");
  etr_clear_a: assert property (clr_s |-> !ch0_compare_reference)
    else $error("reference not cleared");
  force_hi0_a: assert property (hi0_s |-> ch0_compare_reference)
    else $error("reference 0 not forced high");
  force_hi1_a: assert property (hi1_s |-> ch1_compare_reference)
    else $error("reference 1 not forced high");
endmodule
bind tpmc_top tpmc_checker u_chk (.*);
`default_nettype wire

// ==== tb/tpmc_top_tb_top.sv ====
// tpmc_top_tb_top.sv: bus-level tests of the channel pair control block
// assumes: tpmc_top, its checker and tpmc_map.vh on the include path
`timescale 1ns/1ns
`default_nettype none
`include "tpmc_map.vh"
module tpmc_top_tb_top;
  localparam logic [7:0] ca = `TPMC_CTL0_ADDR;
  localparam logic [7:0] st = `TPMC_STAT_ADDR;
  localparam logic [1:0] ok = `TPMC_RESP_OKAY;
  localparam logic [1:0] se = `TPMC_RESP_SLVERR;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, ch1_output_enable, multi_ch1_output_enable, update_event;
  logic filtered_external_trigger, count_down, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, ch0_compare_reference, ch1_compare_reference;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, channel_pair_control_0;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, protection_level, multi_ch1_mode_select, ch_match, ch_below;
  logic [63:0] cw;
  wire [15:0] ch0_add_compare_wr, ch1_add_compare_wr, ch0_compare_wr, ch1_compare_wr;
  wire [15:0] ch0_additional_compare_value, ch1_additional_compare_value;
  wire [15:0] ch0_compare_value, ch1_compare_value;
  wire [63:0] cv;
  wire [1:0] refs = {ch1_compare_reference, ch0_compare_reference};
  logic [4:0] tab [5] = '{5'b00101, 5'b00010, 5'b01011, 5'b11011, 5'b01000};
  int errors = 0;
  int cmp_count = 0;
  // written values in, working copies out, as one word each
  assign {ch0_add_compare_wr, ch1_add_compare_wr, ch0_compare_wr, ch1_compare_wr} = cw;
  assign cv = {ch0_additional_compare_value, ch1_additional_compare_value,
    ch0_compare_value, ch1_compare_value};
  tpmc_top u_dut (.*);
  // free-running clock
  always #5 aclk = ~aclk;
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // one write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask
  // one read, control register data compared with the register port too
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", (a == ca || a == st) ? ok : se, s_axi_rresp);
    if (a == ca) chk("register", e, channel_pair_control_0);
  endtask
  // watchdog
  initial
  begin
    #200000;
    errors++;
    test_done();
  end
  // main sequence
  initial
  begin
    {aclk, aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    {protection_level, multi_ch1_mode_select, ch1_output_enable, multi_ch1_output_enable} = '0;
    {update_event, cw, filtered_external_trigger, ch_match, ch_below, count_down} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ca, 32'h0);
    chk("refs", 0, refs);
    wr(ca, 32'hFFFFFFFF, 4'hF, ok);
    rd(ca, 32'hF000FBFB);
    wr(ca, 32'h000000FF, 4'h1, se);
    rd(ca, 32'hF000FBFB);
    wr(8'h40, 32'h0, 4'hF, se);
    rd(8'h40, 32'h0);
    wr(st, 32'h0, 4'hF, ok);
    rd(ca, 32'hF000FBFB);
    wr(ca, 32'h1, 4'hF, ok);
    $display("test access done");
    @(posedge aclk) protection_level <= 2'h3;
    wr(ca, 32'h10000001, 4'hF, ok);
    rd(ca, 32'h10000001);
    wr(ca, 32'h0, 4'hF, ok);
    wr(ca, 32'h10005000, 4'hF, ok);
    rd(ca, 32'h00005000);
    rd(st, 32'h00000006);
    @(posedge aclk) protection_level <= 2'h0;
    wr(ca, 32'h10000000, 4'hF, ok);
    rd(ca, 32'h10000000);
    $display("test protection done");
    foreach (tab[i])
    begin
      @(posedge aclk) {multi_ch1_mode_select, ch1_output_enable, multi_ch1_output_enable} <= tab[i][4:1];
      wr(ca, 32'h80000000, 4'hF, ok);
      rd(ca, tab[i][0] ? 32'h0 : 32'h80000000);
      @(posedge aclk) {ch1_output_enable, multi_ch1_output_enable} <= 2'b00;
      wr(ca, 32'h0, 4'hF, ok);
    end
    for (int c = 1; c < 5; c = c * 2)
    begin
      wr(ca, {c[2], 21'h0, c[1:0], 8'h0}, 4'hF, ok);
      rd(ca, {c[2], 21'h0, c[1:0], 8'h0});
    end
    $display("test mode done");
    wr(ca, 32'h30000808, 4'hF, ok);
    @(posedge aclk) cw <= 64'h123456789ABCDEF0;
    cyc(3);
    chk("held", 64'h0, cv);
    @(posedge aclk) update_event <= 1'b1;
    @(posedge aclk) update_event <= 1'b0;
    cyc(1);
    chk("loaded", 64'h123456789ABCDEF0, cv);
    wr(ca, 32'h0, 4'hF, ok);
    @(posedge aclk) cw <= 64'h0FEDCBA987654321;
    cyc(2);
    chk("direct", 64'h0FEDCBA987654321, cv);
    $display("test buffering done");
    for (int c = 4; c < 6; c++)
    begin
      wr(ca, 32'h00001010 * c, 4'hF, ok);
      cyc(3);
      chk("forced", {2{c[0]}}, refs);
    end
    wr(ca, 32'h0000D0D0, 4'hF, ok);
    @(posedge aclk) filtered_external_trigger <= 1'b1;
    cyc(6);
    chk("cleared", 0, refs);
    @(posedge aclk) filtered_external_trigger <= 1'b0;
    cyc(6);
    chk("released", 2'b11, refs);
    wr(ca, 32'h00004040, 4'hF, ok);
    wr(ca, 32'h00001010, 4'hF, ok);
    @(posedge aclk) ch_match <= 2'b11;
    cyc(3);
    chk("set", 2'b11, refs);
    wr(ca, 32'h00002020, 4'hF, ok);
    cyc(3);
    chk("clear", 0, refs);
    $display("test references done");
    // pwm modes with the extra compare copies buffered, then toggle
    wr(ca, 32'h30006060, 4'hF, ok);
    @(posedge aclk) {ch_match, ch_below} <= 4'b0001;
    cyc(3);
    chk("pwm0 up", 2'b01, refs);
    @(posedge aclk) {count_down, ch_match, ch_below} <= 5'b11000;
    cyc(3);
    chk("pwm0 down", 2'b10, refs);
    wr(ca, 32'h30007070, 4'hF, ok);
    cyc(3);
    chk("pwm1 down", 2'b01, refs);
    @(posedge aclk) {count_down, ch_match, ch_below} <= 5'b00000;
    wr(ca, 32'h00003030, 4'hF, ok);
    @(posedge aclk) ch_match <= 2'b01;
    @(posedge aclk) ch_match <= 2'b00;
    cyc(3);
    chk("toggle", 2'b10, refs);
    $display("test pwm done");
    // second reset in mid-run returns the register to its reset value
    @(posedge aclk) aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    rd(ca, 32'h0);
    chk("reset refs", 0, refs);
    $display("test reset done");
    test_done();
  end
endmodule
`default_nettype wire
